//--- fma_consts.svh
// Register offsets, field positions and fixed values of the fused multiply-add block
`ifndef FMA_CONSTS_SVH
`define FMA_CONSTS_SVH
// Register byte offsets
`define FMA_OFF_CSR   4'h0
`define FMA_OFF_FEAT  4'h4
`define FMA_OFF_ISTAT 4'h8
`define FMA_OFF_IMASK 4'hC
// Control/status layout: flags 5:0, masks 11:6, rounding mode 13:12
`define FMA_CSR_W     14
`define FMA_CSR_MLSB  6
`define FMA_CSR_RLSB  12
`define FMA_CSR_RESET 14'h0FC0
// Exception bit positions in the flag and mask fields
`define FMA_EX_NV 0
`define FMA_EX_DE 1
`define FMA_EX_OE 3
`define FMA_EX_UE 4
`define FMA_EX_PE 5
// Feature word bits
`define FMA_FEAT_FMA  12
`define FMA_FEAT_OSSV 27
`define FMA_FEAT_WIDE 28
// Immediate control byte bits
`define FMA_IMM_RSEL 2
`define FMA_IMM_SUPP 3
// Interrupt status bits
`define FMA_IRQ_DONE 0
`define FMA_IRQ_TRAP 1
// Format figures: exponent bias, significand bits, default NaN, infinity and quiet bit
`define FMA_BIAS_D 1023
`define FMA_BIAS_S 127
`define FMA_P_D    53
`define FMA_P_S    24
`define FMA_DQNAN_D 64'hFFF8000000000000
`define FMA_DQNAN_S 32'hFFC00000
`define FMA_INF_D   64'h7FF0000000000000
`define FMA_INF_S   32'h7F800000
`define FMA_QBIT_D  64'h0008000000000000
`define FMA_QBIT_S  32'h00400000
// Exact-sum window: width, product offset, highest addend offset
`define FMA_W    170
`define FMA_POFS 58
`define FMA_CTOP 116
`endif

//--- fma_pkg.sv
// Types shared by the fused multiply-add block
`default_nettype none
package fma_pkg;
   typedef enum logic [1:0] {
      FMA_RNE = 2'h0,
      FMA_RDN = 2'h1,
      FMA_RUP = 2'h2,
      FMA_RTZ = 2'h3
   } fma_rm_t;
   // Unpacked operand: value is man * 2^exp
   typedef struct packed {
      logic               sgn;
      logic               nan;
      logic               snan;
      logic               inf;
      logic               zero;
      logic               sub;
      logic signed [13:0] exp;
      logic [52:0]        man;
   } fma_op_t;
endpackage
`default_nettype wire

//--- fma_csr_if.sv
// Link between the datapath and its control/status registers
`default_nettype none
interface fma_csr_if;
   import fma_pkg::*;
   fma_rm_t    rm;
   logic [5:0] exc_mask;
   logic [5:0] flag_set;
   logic       done;
   logic       trap;
   modport regs (output rm, exc_mask, input flag_set, done, trap);
   modport core (input rm, exc_mask, output flag_set, done, trap);
endinterface
`default_nettype wire

//--- fma_round.sv
// Single rounding of an exact magnitude to single or double precision
`include "fma_consts.svh"
`default_nettype none
module fma_round
   import fma_pkg::*;
(
   input  wire logic                    dbl,
   input  wire fma_rm_t                 rm,
   input  wire logic                    sgn,
   input  wire logic [`FMA_W-1:0]       mag,
   input  wire logic signed [13:0]      base,
   output logic      [63:0]             res,
   output logic                         ovf,
   output logic                         unf,
   output logic                         inx
);
   int                p, emin, emax, k, e, q, s, be;
   logic [`FMA_W-1:0] kept;
   logic [54:0]       m;
   logic              rb, st, inc, tiny, maxfin;

   // Locate the leading one, pick the lsb weight, round once, then pack
   always_comb begin
      p    = dbl ? `FMA_P_D : `FMA_P_S;
      emax = dbl ? `FMA_BIAS_D : `FMA_BIAS_S;
      emin = 1 - emax;
      k    = 0;
      for (int i = 0; i < `FMA_W; i++) begin
         if (mag[i]) k = i;
      end
      e    = int'(base) + k;
      tiny = e < emin;                            // Tininess judged before rounding
      q    = tiny ? emin - (p - 1) : e - (p - 1); // Exponent bounded to the format
      s    = q - int'(base);
      if (s <= 0) begin
         kept = mag << (-s);
         rb   = 1'b0;
         st   = 1'b0;
      end else if (s > `FMA_W) begin
         kept = '0;
         rb   = 1'b0;
         st   = |mag;
      end else begin
         kept = mag >> s;
         rb   = mag[s-1];
         st   = |(mag << (`FMA_W + 1 - s));
      end
      case (rm)
         FMA_RNE: inc = rb & (st | kept[0]);
         FMA_RDN: inc = sgn & (rb | st);
         FMA_RUP: inc = ~sgn & (rb | st);
         default: inc = 1'b0;
      endcase
      m = kept[54:0] + {54'h0, inc};             // Only rounding step
      if (m[p]) begin
         m = m >> 1;
         q = q + 1;
      end
      be     = m[p-1] ? q + p - 1 + emax : 0;
      ovf    = m[p-1] && (q + p - 1 > emax);
      inx    = rb | st | ovf;
      unf    = tiny & inx;
      maxfin = rm == FMA_RTZ || (rm == FMA_RDN && !sgn) || (rm == FMA_RUP && sgn);
      // Overflow saturates to the largest finite value when rounding away from infinity
      if (dbl) begin
         res = {sgn, be[10:0], m[51:0]};
         if (ovf) res = maxfin ? {sgn, 11'h7FE, {52{1'b1}}} : {sgn, 11'h7FF, 52'h0};
      end else begin
         res = {32'h0, sgn, be[7:0], m[22:0]};
         if (ovf) res = maxfin ? {32'h0, sgn, 8'hFE, {23{1'b1}}} : {32'h0, sgn, 8'hFF, 23'h0};
      end
   end
endmodule
`default_nettype wire

//--- fma_regs.sv
// Control/status, feature, interrupt status and mask registers
`include "fma_consts.svh"
`default_nettype none
module fma_regs
   import fma_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic        os_state_save_enabled_flag,
   output logic      [31:0] rdata,
   output logic             irq,
   fma_csr_if.regs          csr
);
   logic [`FMA_CSR_W-1:0] csr_reg;
   logic [1:0]            istat_reg, imask_reg, ev;
   logic [31:0]           rdata_reg, feat;
   logic                  irq_reg;

   assign csr.rm       = fma_rm_t'(csr_reg[`FMA_CSR_RLSB+:2]);
   assign csr.exc_mask = csr_reg[`FMA_CSR_MLSB+:6];
   assign rdata        = rdata_reg;
   assign irq          = irq_reg;

   // Feature word; software tests it together with the enabled-state mask
   always_comb begin
      feat                 = 32'h0;
      feat[`FMA_FEAT_FMA]  = 1'b1;
      feat[`FMA_FEAT_WIDE] = 1'b1;
      feat[`FMA_FEAT_OSSV] = os_state_save_enabled_flag;
      ev                   = 2'h0;
      ev[`FMA_IRQ_DONE]    = csr.done;
      ev[`FMA_IRQ_TRAP]    = csr.trap;
   end

   // Control/status: a hardware flag set wins over a software write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         csr_reg <= `FMA_CSR_RESET;
      end else if (ce) begin
         if (wr && addr == `FMA_OFF_CSR) begin
            csr_reg <= wdata[`FMA_CSR_W-1:0] | {8'h0, csr.flag_set};
         end else begin
            csr_reg[5:0] <= csr_reg[5:0] | csr.flag_set;
         end
      end
   end

   // Sticky events, write one to clear, a new event beats the clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         istat_reg <= 2'h0;
         imask_reg <= 2'h0;
         irq_reg   <= 1'b0;
      end else if (ce) begin
         istat_reg <= (istat_reg & ~((wr && addr == `FMA_OFF_ISTAT) ? wdata[1:0] : 2'h0)) | ev;
         if (wr && addr == `FMA_OFF_IMASK) imask_reg <= wdata[1:0];
         irq_reg   <= |(istat_reg & imask_reg);
      end
   end

   // Read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 32'h0;
      end else if (ce) begin
         case (rd ? addr : 4'h1)
            `FMA_OFF_CSR:   rdata_reg <= {18'h0, csr_reg};
            `FMA_OFF_FEAT:  rdata_reg <= feat;
            `FMA_OFF_ISTAT: rdata_reg <= {30'h0, istat_reg};
            `FMA_OFF_IMASK: rdata_reg <= {30'h0, imask_reg};
            default:        rdata_reg <= 32'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- fma_top.sv
// Fused multiply-add vector datapath with special-case handling and registers
`include "fma_consts.svh"
`default_nettype none
module fma_top
   import fma_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic [3:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [31:0]  reg_rdata,
   output logic              irq,
   input  wire logic         os_state_save_enabled_flag,
   input  wire logic         issue_valid,
   input  wire logic [1:0]   issue_neg,
   input  wire logic         issue_double,
   input  wire logic         issue_wide,
   input  wire logic [7:0]   immediate_control_byte,
   input  wire logic [255:0] src_x,
   input  wire logic [255:0] src_y,
   input  wire logic [255:0] src_z,
   input  wire logic [255:0] dst_old,
   output logic              res_valid,
   output logic              res_write,
   output logic      [255:0] res_data,
   output logic              fp_trap
);
   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------

   // Split a raw element into sign, class, integer significand and lsb exponent
   function automatic fma_op_t fma_unpack(input logic [63:0] r, input logic dbl);
      fma_op_t     o;
      logic [10:0] ef;
      logic [51:0] fr;
      logic        top;
      int          bias;
      ef     = dbl ? r[62:52] : {3'h0, r[30:23]};
      fr     = dbl ? r[51:0] : {29'h0, r[22:0]};
      top    = ef == (dbl ? 11'h7FF : 11'h0FF);
      bias   = dbl ? `FMA_BIAS_D : `FMA_BIAS_S;
      o.sgn  = dbl ? r[63] : r[31];
      o.inf  = top && fr == 52'h0;
      o.nan  = top && fr != 52'h0;
      o.snan = o.nan && !(dbl ? fr[51] : fr[22]);
      o.zero = ef == 11'h0 && fr == 52'h0;
      o.sub  = ef == 11'h0 && fr != 52'h0;
      o.man  = dbl ? {ef != 11'h0, fr} : {29'h0, ef != 11'h0, fr[22:0]};
      o.exp  = 14'((ef == 11'h0 ? 1 : int'(ef)) - bias - (dbl ? `FMA_P_D : `FMA_P_S) + 1);
      return o;
   endfunction

   // Force the sign bit of an element
   function automatic logic [63:0] fma_sgn(input logic [63:0] r, input logic s,
                                           input logic dbl);
      logic [63:0] o;
      o = r;
      if (dbl) o[63] = s;
      else o[31] = s;
      return o;
   endfunction

   // Right shift keeping any lost bit as a sticky lsb
   function automatic logic [`FMA_W-1:0] fma_shr(input logic [`FMA_W-1:0] v, input int n);
      logic [`FMA_W-1:0] o;
      o    = v >> n;
      o[0] = o[0] | ((n >= `FMA_W) ? |v : |(v << (`FMA_W - n)));
      return o;
   endfunction

   // ------------------------------------------------------------------
   // Registers and control
   // ------------------------------------------------------------------

   fma_csr_if csr ();

   fma_rm_t       rm;
   logic [63:0]   dqnan, infv;
   logic [5:0]    fl_all, fl_eff;
   logic [255:0]  res_d;
   logic          trap_now;
   logic [7:0]    lane_act;
   wire  [63:0]   lane_res [8];
   wire  [5:0]    lane_fl [8];
   logic          res_valid_reg, res_write_reg, fp_trap_reg;
   logic [255:0]  res_data_reg;

   fma_regs u_regs (
      .clk                        (clk),
      .resetn                     (resetn),
      .ce                         (ce),
      .addr                       (reg_addr),
      .wdata                      (reg_wdata),
      .wr                         (reg_wr),
      .rd                         (reg_rd),
      .os_state_save_enabled_flag (os_state_save_enabled_flag),
      .rdata                      (reg_rdata),
      .irq                        (irq),
      .csr                        (csr.regs)
   );

   // Rounding mode source and per-precision constants
   always_comb begin
      rm    = immediate_control_byte[`FMA_IMM_RSEL] ?
              fma_rm_t'(immediate_control_byte[1:0]) : csr.rm;
      dqnan = issue_double ? `FMA_DQNAN_D : {32'h0, `FMA_DQNAN_S};
      infv  = issue_double ? `FMA_INF_D : {32'h0, `FMA_INF_S};
   end

   // ------------------------------------------------------------------
   // Element lanes: four double or eight single elements
   // ------------------------------------------------------------------

   for (genvar i = 0; i < 8; i++) begin : g_lane
      fma_op_t            a, b, c;
      logic [63:0]        rx, ry, rz, spec, rres;
      logic [105:0]       pm;
      logic [`FMA_W-1:0]  pw, cw, mag;
      logic signed [13:0] base;
      logic [5:0]         fl;
      logic               psgn, csgn, is_spec, sgn, zsum, ovf, unf, inx;
      int                 pe, t;

      // Upper half idles in the narrow width
      assign lane_act[i] = issue_double ? (i < 2 || (issue_wide && i < 4)) :
                                          (i < 4 || issue_wide);
      assign rx = issue_double ? src_x[64*(i%4)+:64] : {32'h0, src_x[32*i+:32]};
      assign ry = issue_double ? src_y[64*(i%4)+:64] : {32'h0, src_y[32*i+:32]};
      assign rz = issue_double ? src_z[64*(i%4)+:64] : {32'h0, src_z[32*i+:32]};

      // Classification and the special-value results
      always_comb begin
         a       = fma_unpack(rx, issue_double);
         b       = fma_unpack(ry, issue_double);
         c       = fma_unpack(rz, issue_double);
         psgn    = a.sgn ^ b.sgn ^ issue_neg[1];
         csgn    = c.sgn ^ issue_neg[0];
         fl      = 6'h0;
         spec    = 64'h0;
         is_spec = 1'b1;
         if (a.nan || b.nan || c.nan) begin
            // First NaN in operand order, made quiet
            spec = a.nan ? rx : (b.nan ? ry : rz);
            spec = spec | (issue_double ? `FMA_QBIT_D : {32'h0, `FMA_QBIT_S});
            fl[`FMA_EX_NV] = a.snan | b.snan | c.snan;
         end else if ((a.inf && b.zero) || (a.zero && b.inf)) begin
            spec           = dqnan;
            fl[`FMA_EX_NV] = 1'b1;
         end else if (a.inf || b.inf) begin
            if (c.inf && psgn != csgn) begin
               spec           = dqnan;
               fl[`FMA_EX_NV] = 1'b1;
            end else begin
               spec = fma_sgn(infv, psgn, issue_double);
            end
         end else if (c.inf) begin
            spec = fma_sgn(infv, csgn, issue_double);
         end else if (a.zero || b.zero) begin
            if (c.zero) begin
               // Like signs keep the sign, unlike give minus only rounding down
               spec = fma_sgn(64'h0, (psgn == csgn) ? psgn : (rm == FMA_RDN),
                              issue_double);
            end else begin
               spec = fma_sgn(rz, csgn, issue_double);
            end
         end else begin
            is_spec = 1'b0;
         end
         // Denormal operand flag only when no NaN decides the result
         fl[`FMA_EX_DE] = !(a.nan || b.nan || c.nan) && (a.sub || b.sub || c.sub);
      end

      // Exact product and addend aligned in one window
      always_comb begin
         pm   = a.man * b.man;
         pe   = int'(a.exp) + int'(b.exp);
         t    = int'(c.exp) - pe + `FMA_POFS;
         pw   = `FMA_W'(pm) << `FMA_POFS;
         base = 14'(pe - `FMA_POFS);
         if (c.zero) begin
            cw = '0;
         end else if (t > `FMA_CTOP) begin
            // Addend above the top offset: pin it there, the product shifts down with lost bits kept as sticky
            cw   = `FMA_W'(c.man) << `FMA_CTOP;
            base = 14'(int'(c.exp) - `FMA_CTOP);
            pw   = fma_shr(pw, t - `FMA_CTOP);
         end else if (t < 0) begin
            cw = fma_shr(`FMA_W'(c.man), -t);
         end else begin
            cw = `FMA_W'(c.man) << t;
         end
         // Signed sum of the aligned terms; bits shifted out during alignment survive only as a sticky lsb
         if (psgn == csgn) begin
            mag = pw + cw;
            sgn = psgn;
         end else if (pw >= cw) begin
            mag = pw - cw;
            sgn = psgn;
         end else begin
            mag = cw - pw;
            sgn = csgn;
         end
         zsum = mag == '0;
      end

      fma_round u_round (
         .dbl  (issue_double),
         .rm   (rm),
         .sgn  (sgn),
         .mag  (mag),
         .base (base),
         .res  (rres),
         .ovf  (ovf),
         .unf  (unf),
         .inx  (inx)
      );

      // Exact cancellation gives a zero signed by the rounding mode
      assign lane_res[i] = is_spec ? spec :
                           zsum ? fma_sgn(64'h0, rm == FMA_RDN, issue_double) : rres;
      assign lane_fl[i]  = (is_spec || zsum) ? fl :
                           (fl | {inx, unf, ovf, 3'h0});
   end

   // ------------------------------------------------------------------
   // Merge lanes and exceptions
   // ------------------------------------------------------------------

   // Inactive upper lanes are filled with zero
   always_comb begin
      res_d  = 256'h0;
      fl_all = 6'h0;
      for (int j = 0; j < 8; j++) begin
         if (lane_act[j]) begin
            fl_all = fl_all | lane_fl[j];
            if (issue_double) res_d[64*(j%4)+:64] = lane_res[j];
            else res_d[32*j+:32] = lane_res[j][31:0];
         end
      end
   end

   // Suppression drops every exception: no flag is recorded and nothing traps
   assign fl_eff   = immediate_control_byte[`FMA_IMM_SUPP] ? 6'h0 : fl_all;
   assign trap_now = |(fl_eff & ~csr.exc_mask);

   assign csr.flag_set = issue_valid ? fl_eff : 6'h0;
   assign csr.done     = issue_valid;
   assign csr.trap     = issue_valid & trap_now;

   // ------------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------------

   // Handshake outputs, one cycle after the issue
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         res_valid_reg <= 1'b0;
         res_write_reg <= 1'b0;
         fp_trap_reg   <= 1'b0;
      end else if (ce) begin
         res_valid_reg <= issue_valid;
         res_write_reg <= issue_valid & ~trap_now;
         fp_trap_reg   <= issue_valid & trap_now;
      end
   end

   // Result word; a trapped operation hands back the old destination
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         res_data_reg <= 256'h0;
      end else if (ce && issue_valid) begin
         res_data_reg <= trap_now ? dst_old : res_d;
      end
   end

   assign res_valid = res_valid_reg;
   assign res_write = res_write_reg;
   assign res_data  = res_data_reg;
   assign fp_trap   = fp_trap_reg;
endmodule
`default_nettype wire

//--- fma_dest_model.sv
// Destination register model standing behind the result port
`default_nettype none
module fma_dest_model (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         res_valid,
   input  wire logic         res_write,
   input  wire logic [255:0] res_data,
   output logic      [255:0] dst_old
);
   timeunit 1ns;
   timeprecision 1ps;
   // Odd pattern at reset, so a trap that leaks zeros shows up
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dst_old <= {8{32'hC3A55A3C}};
      end else if (res_valid && res_write) begin
         dst_old <= res_data; // Trapped results never land
      end
   end
endmodule
`default_nettype wire

//--- fma_top_checker.sv
// Port-level assertions for the fused multiply-add block
`default_nettype none
module fma_top_checker (
   input wire logic         clk,
   input wire logic         resetn,
   input wire logic         ce,
   input wire logic [3:0]   reg_addr,
   input wire logic         reg_rd,
   input wire logic [31:0]  reg_rdata,
   input wire logic         issue_valid,
   input wire logic         issue_wide,
   input wire logic [7:0]   immediate_control_byte,
   input wire logic [255:0] dst_old,
   input wire logic         res_valid,
   input wire logic         res_write,
   input wire logic [255:0] res_data,
   input wire logic         fp_trap
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----
   // Result port
   // ----
   a_answer_next: assert property (ce && issue_valid |=> res_valid)
      else $error("no result after issue");
   a_no_spurious: assert property (ce && !issue_valid |=> !res_valid && $stable(res_data))
      else $error("result without issue");
   a_write_or_trap: assert property (res_valid |-> res_write ^ fp_trap)
      else $error("write and trap not exclusive");
   a_idle_quiet: assert property (!res_valid |-> !res_write && !fp_trap)
      else $error("write or trap outside result");
   a_trap_keeps: assert property (ce && issue_valid |=> !fp_trap || res_data == $past(dst_old))
      else $error("trap changed destination");
   a_suppress_writes: assert property (ce && issue_valid && immediate_control_byte[3] |=> res_write)
      else $error("suppressed op trapped");
   a_narrow_upper: assert property (ce && issue_valid && !issue_wide |=> fp_trap || res_data[255:128] == 128'h0)
      else $error("narrow upper half not zero");
   // ----
   // Register port
   // ----
   a_feature_bit: assert property (ce && reg_rd && reg_addr == 4'h4 |=> reg_rdata[12])
      else $error("feature bit missing");
   a_read_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read");
   c_trap: cover property (fp_trap);
   c_suppress: cover property (ce && issue_valid && immediate_control_byte[3]);
   c_feature: cover property (ce && reg_rd && reg_addr == 4'h4);
endmodule
bind fma_top fma_top_checker u_fma_top_checker (.clk, .resetn, .ce, .reg_addr, .reg_rd,
   .reg_rdata, .issue_valid, .issue_wide, .immediate_control_byte, .dst_old, .res_valid,
   .res_write, .res_data, .fp_trap);
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the fused multiply-add block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk = 1'b0, resetn = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]   reg_addr = 4'h0;
   logic [31:0]  reg_wdata = 32'h0, reg_rdata;
   logic         os_state_save_enabled_flag = 1'b1, issue_valid = 1'b0, issue_double = 1'b1;
   logic         issue_wide = 1'b1, irq, res_valid, res_write, fp_trap;
   logic [1:0]   issue_neg = 2'h0;
   logic [7:0]   immediate_control_byte = 8'h00;
   logic [255:0] src_x = '0, src_y = '0, src_z = '0, dst_old, res_data;
   int           failures = 0, compares = 0, cycles = 0;
   fma_top u_fma_top (.clk, .resetn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .irq, .os_state_save_enabled_flag, .issue_valid, .issue_neg, .issue_double, .issue_wide,
      .immediate_control_byte, .src_x, .src_y, .src_z, .dst_old, .res_valid, .res_write,
      .res_data, .fp_trap);
   fma_dest_model u_fma_dest_model (.clk, .resetn, .res_valid, .res_write, .res_data, .dst_old);
   // ----
   // Clock, watchdog and checking helpers
   // ----
   always #2 clk = ~clk;
   // A hang costs a mismatch instead of a stuck run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         close_out();
      end
   end
   task automatic close_out();
      if (failures == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // Same operands in every lane; a trap must hand back the old destination
   task automatic op(input logic [63:0] x, y, z, input logic [1:0] n, input logic [7:0] im,
                     input logic w, input logic [63:0] e, input logic t);
      logic [255:0] keep;
      @(posedge clk);
      issue_valid <= 1'b1;
      {src_x, src_y, src_z} <= {{4{x}}, {4{y}}, {4{z}}};
      {issue_neg, immediate_control_byte, issue_wide} <= {n, im, w};
      @(posedge clk);
      keep = dst_old;
      issue_valid <= 1'b0;
      #1 chk({res_valid, res_write, fp_trap}, {1'b1, !t, t});
      chk(res_data, t ? keep : (w ? {4{e}} : {128'h0, e, e}));
   endtask
   task automatic irq_is(input logic e);
      @(posedge clk);
      #1 chk(irq, e);
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h0, 32'h00000FC0);
      wr(4'h4, 32'h0);
      rd(4'h4, 32'h18001000);
      wr(4'h2, 32'hFFFFFFFF);
      rd(4'h2, 32'h0);
      op(64'h0, 64'h0, 64'h8000000000000000, 2'h0, 8'h05, 1'b1, 64'h8000000000000000, 1'b0);
      op(64'h0, 64'h0, 64'h8000000000000000, 2'h0, 8'h04, 1'b1, 64'h0, 1'b0);
      op(64'h8000000000000000, 64'h3FF0000000000000, 64'h8000000000000000, 2'h3, 8'h00, 1'b0,
         64'h0, 1'b0);
      op(64'h4000000000000000, 64'h3FF8000000000000, 64'hFFF0000000000000, 2'h1, 8'h00, 1'b1,
         64'h7FF0000000000000, 1'b0);
      op(64'h0, 64'h4000000000000000, 64'h3FF8000000000000, 2'h1, 8'h00, 1'b1,
         64'hBFF8000000000000, 1'b0);
      op(64'h3FF8000000000000, 64'h4000000000000000, 64'h0, 2'h2, 8'h00, 1'b1,
         64'hC008000000000000, 1'b0);
      op(64'h7FF0000000000000, 64'h0, 64'h3FF0000000000000, 2'h0, 8'h00, 1'b1,
         64'hFFF8000000000000, 1'b0);
      wr(4'h0, 32'h00001FC0);
      op(64'h3FF8000000000000, 64'h4000000000000000, 64'h4008000000000000, 2'h1, 8'h00, 1'b1,
         64'h8000000000000000, 1'b0);
      wr(4'h0, 32'h00000FC0);
      op(64'h3FF0000000000001, 64'h3FF0000000000001, 64'hBFF0000000000000, 2'h0, 8'h00, 1'b1,
         64'h3CC0000000000000, 1'b0);
      op(64'h3FF0000000000001, 64'h3FF0000000000001, 64'hBFF0000000000000, 2'h0, 8'h06, 1'b1,
         64'h3CC0000000000001, 1'b0);
      op(64'h7FEFFFFFFFFFFFFF, 64'h4000000000000000, 64'h0, 2'h0, 8'h07, 1'b1,
         64'h7FEFFFFFFFFFFFFF, 1'b0);
      @(posedge clk) issue_double <= 1'b0;
      op(64'h3F8000013F800001, 64'h3F8000013F800001, 64'hBF800000BF800000, 2'h0, 8'h00, 1'b0,
         64'h3480000034800000, 1'b0);
      op(64'h3F8000013F800001, 64'h3F8000013F800001, 64'hBF800000BF800000, 2'h0, 8'h06, 1'b1,
         64'h3480000134800001, 1'b0);
      @(posedge clk) issue_double <= 1'b1;
      rd(4'h0, 32'h00000FE8);
      wr(4'h0, 32'h000007C0);
      op(64'h3FF0000000000001, 64'h3FF0000000000001, 64'hBFF0000000000000, 2'h0, 8'h06, 1'b1,
         64'h0, 1'b1);
      rd(4'h0, 32'h000007E0);
      wr(4'h0, 32'h000007C0);
      op(64'h3FF0000000000001, 64'h3FF0000000000001, 64'hBFF0000000000000, 2'h0, 8'h0E, 1'b1,
         64'h3CC0000000000001, 1'b0);
      rd(4'h0, 32'h000007C0);
      rd(4'h8, 32'h00000003);
      wr(4'hC, 32'h00000002);
      irq_is(1'b1);
      wr(4'hC, 32'h0);
      irq_is(1'b0);
      wr(4'hC, 32'h00000003);
      wr(4'h8, 32'h00000003);
      irq_is(1'b0);
      // A write while the clock enable is low must be ignored
      @(posedge clk) ce <= 1'b0;
      wr(4'hC, 32'h0);
      @(posedge clk) ce <= 1'b1;
      rd(4'hC, 32'h00000003);
      close_out();
   end
endmodule
`default_nettype wire
